/* File: wlr_pkg.sv */
// Purpose: Shared constants for the wake listen radio configuration block
// Assumes: Byte-wide retained registers on an 11-bit register address
// Notes: Offsets are byte addresses in the configuration map
package wlr_pkg;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_LISTEN_WINDOW = 11'h106;
  localparam logic [ADDR_W-1:0] ADDR_TICK_DIVIDER = 11'h107;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_THRESHOLD = 11'h108;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_BYTE0 = 11'h109;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_BYTE1 = 11'h10a;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_BYTE2 = 11'h10b;
  localparam logic [ADDR_W-1:0] ADDR_BIT_RATE_LOW = 11'h10c;
  localparam logic [ADDR_W-1:0] ADDR_BIT_RATE_HIGH = 11'h10d;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;
  localparam int unsigned TICK_PRESCALE = 128;
  localparam int unsigned PRESCALE_W = 15;
  localparam int unsigned THRESH_OFFSET_DBM = 107;
  localparam int unsigned PFD_FREQ_HZ = 26_000_000;
  localparam int unsigned FRAC_BITS = 16;
  localparam int unsigned RATE_STEP_BPS = 100;
  localparam int unsigned RATE_HIGH_LSB = 0;
  localparam int unsigned RATE_HIGH_W = 4;
  localparam int unsigned FREQ_W = 33;
  localparam int unsigned BPS_W = 19;
  typedef enum logic [1:0] {WLR_SLEEP, WLR_LISTEN, WLR_RECEIVE} wlr_state_type;
endpackage

/* File: wlr_listen_timer.sv */
// Purpose: Listening window timer counting prescaled ticks of the 6.5 MHz clock
// Assumes: osc_tick is a one-cycle pulse per 6.5 MHz period, synchronous to clk_sys
// Notes: A zero divider ticks on every oscillator pulse
`timescale 1ns/1ns
module wlr_listen_timer
  import wlr_pkg::*;
#(
  parameter int unsigned DIV_W = 8,
  parameter int unsigned WIN_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic osc_tick,
  input wire logic [DIV_W-1:0] divider,
  input wire logic [WIN_W-1:0] window,
  output logic running,
  output logic expired
);
  logic [PRESCALE_W-1:0] pre_q;
  logic [WIN_W-1:0] tick_cnt_q;
  logic running_q;
  logic [PRESCALE_W-1:0] pre_target;
  logic tick;

  // Tick period is 128 times the divider in oscillator cycles
  assign pre_target = PRESCALE_W'(TICK_PRESCALE) * PRESCALE_W'(divider);
  assign tick = running_q && osc_tick && ((pre_q + 1'b1) >= pre_target);

  always_ff @(posedge clk_sys) begin
    if (rst || start || !running_q) begin
      pre_q <= '0;
    end else if (osc_tick) begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || start) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Window ends after window ticks; a zero window ends at once
  always_comb begin
    expired = running_q && (window == '0 ||
      (tick && (tick_cnt_q + 1'b1) == window));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= 1'b1;
    end else if (stop || expired) begin
      running_q <= 1'b0;
    end
  end

  assign running = running_q;
endmodule

/* File: wlr_config_bank.sv */
// Purpose: Retained radio configuration registers and autonomous wake sequencing
// Assumes: Register port is the byte-wide path behind the serial host interface
// Notes: Window timer counts oscillator pulses, not system clocks
// Summary of operation
// - On a wake-up timer expiry with autonomous wake mode on, power the radio and start rx.
// - If no preamble is seen before the listening window ends, go back to sleep.
// - The listening window lasts the listen-window count times the tick period.
// - The tick period is 128 times the tick divider in cycles of the 6.5 MHz clock.
// - With signal detection on, compare RSSI with the threshold register minus 107 dBm.
// - The channel frequency is 26 MHz times the 24-bit channel word over 2 to the 16.
// - The channel word is spread low byte first over three consecutive registers.
// - The data rate is the 12-bit rate word times 100 bits per second.
// - The rate word's upper four bits sit in bits 3 to 0 of the next register.
// - Raise the enabled detect interrupt when wake-mode RSSI passes the threshold.
`timescale 1ns/1ns
module wlr_config_bank
  import wlr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic autonomous_wake_enable,
  input wire logic rssi_detect_enable,
  input wire logic wake_signal_detect_irq_enable,
  input wire logic wake_up_timer_expired,
  input wire logic osc_tick,
  input wire logic preamble_detected,
  input wire logic receive_done,
  input wire logic rssi_valid,
  input wire logic signed [DATA_W-1:0] rssi_dbm,
  output logic radio_power_up,
  output logic rx_enable,
  output logic sleep_request,
  output logic listening,
  output logic wake_signal_detect_irq,
  output logic [23:0] channel_word,
  output logic [FREQ_W-1:0] channel_word_hz,
  output logic [11:0] data_rate_word,
  output logic [BPS_W-1:0] data_rate_bps
);
  logic [DATA_W-1:0] listen_window_q;
  logic [DATA_W-1:0] tick_divider_q;
  logic [DATA_W-1:0] wake_threshold_q;
  logic [DATA_W-1:0] channel_byte0_q;
  logic [DATA_W-1:0] channel_byte1_q;
  logic [DATA_W-1:0] channel_byte2_q;
  logic [DATA_W-1:0] bit_rate_low_q;
  logic [DATA_W-1:0] bit_rate_high_q;
  wlr_state_type state_q;
  logic sleep_q;
  logic irq_q;
  logic [FREQ_W-1:0] freq_q;
  logic [BPS_W-1:0] bps_q;
  logic wake_start;
  logic window_expired;
  logic window_running;
  localparam int unsigned PROD_W = FREQ_W + FRAC_BITS;
  localparam int unsigned THR_W = DATA_W + 2;
  logic signed [THR_W-1:0] thresh_dbm;
  logic rssi_above;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      listen_window_q <= REG_RESET;
      tick_divider_q <= REG_RESET;
      wake_threshold_q <= REG_RESET;
      channel_byte0_q <= REG_RESET;
      channel_byte1_q <= REG_RESET;
      channel_byte2_q <= REG_RESET;
      bit_rate_low_q <= REG_RESET;
      bit_rate_high_q <= REG_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, ADDR_LISTEN_WINDOW)) begin
        listen_window_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_TICK_DIVIDER)) begin
        tick_divider_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_WAKE_THRESHOLD)) begin
        wake_threshold_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_CHANNEL_BYTE0)) begin
        channel_byte0_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_CHANNEL_BYTE1)) begin
        channel_byte1_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_CHANNEL_BYTE2)) begin
        channel_byte2_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_BIT_RATE_LOW)) begin
        bit_rate_low_q <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_BIT_RATE_HIGH)) begin
        bit_rate_high_q <= reg_wdata;
      end
    end
  end

  // Read mux, combinational
  always_comb begin
    if (hit(reg_addr, ADDR_LISTEN_WINDOW)) begin
      reg_rdata = listen_window_q;
    end else if (hit(reg_addr, ADDR_TICK_DIVIDER)) begin
      reg_rdata = tick_divider_q;
    end else if (hit(reg_addr, ADDR_WAKE_THRESHOLD)) begin
      reg_rdata = wake_threshold_q;
    end else if (hit(reg_addr, ADDR_CHANNEL_BYTE0)) begin
      reg_rdata = channel_byte0_q;
    end else if (hit(reg_addr, ADDR_CHANNEL_BYTE1)) begin
      reg_rdata = channel_byte1_q;
    end else if (hit(reg_addr, ADDR_CHANNEL_BYTE2)) begin
      reg_rdata = channel_byte2_q;
    end else if (hit(reg_addr, ADDR_BIT_RATE_LOW)) begin
      reg_rdata = bit_rate_low_q;
    end else if (hit(reg_addr, ADDR_BIT_RATE_HIGH)) begin
      reg_rdata = bit_rate_high_q;
    end else begin
      reg_rdata = READ_UNMAPPED;
    end
  end

  assign channel_word = {channel_byte2_q, channel_byte1_q, channel_byte0_q};
  assign data_rate_word = {bit_rate_high_q[RATE_HIGH_LSB +: RATE_HIGH_W], bit_rate_low_q};

  // Derived frequency and data rate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_q <= '0;
      bps_q <= '0;
    end else begin
      freq_q <= FREQ_W'((PROD_W'(PFD_FREQ_HZ) * PROD_W'(channel_word)) >> FRAC_BITS);
      bps_q <= BPS_W'(BPS_W'(RATE_STEP_BPS) * BPS_W'(data_rate_word));
    end
  end

  assign channel_word_hz = freq_q;
  assign data_rate_bps = bps_q;

  // Wake sequencing
  assign wake_start = (state_q == WLR_SLEEP) && wake_up_timer_expired
    && autonomous_wake_enable;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= WLR_SLEEP;
    end else begin
      unique case (state_q)
        WLR_SLEEP: begin
          if (wake_start) begin
            state_q <= WLR_LISTEN;
          end
        end
        WLR_LISTEN: begin
          if (preamble_detected) begin
            state_q <= WLR_RECEIVE;
          end else if (window_expired) begin
            state_q <= WLR_SLEEP;
          end
        end
        WLR_RECEIVE: begin
          if (receive_done) begin
            state_q <= WLR_SLEEP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= ((state_q == WLR_LISTEN) && !preamble_detected && window_expired)
        || ((state_q == WLR_RECEIVE) && receive_done);
    end
  end

  assign radio_power_up = (state_q != WLR_SLEEP);
  assign rx_enable = (state_q != WLR_SLEEP);
  assign sleep_request = sleep_q;
  assign listening = window_running;

  wlr_listen_timer #(
    .DIV_W(DATA_W),
    .WIN_W(DATA_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(wake_start),
    .stop(preamble_detected),
    .osc_tick(osc_tick),
    .divider(tick_divider_q),
    .window(listen_window_q),
    .running(window_running),
    .expired(window_expired)
  );

  // Signal threshold in dBm
  assign thresh_dbm = $signed({2'b00, wake_threshold_q}) - $signed(THR_W'(THRESH_OFFSET_DBM));
  assign rssi_above = rssi_detect_enable && rssi_valid && (state_q != WLR_SLEEP)
    && ($signed(THR_W'(rssi_dbm)) > thresh_dbm);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= rssi_above && wake_signal_detect_irq_enable;
    end
  end

  assign wake_signal_detect_irq = irq_q;
endmodule

/* File: wlr_config_bank_props.sv */
// Purpose: Port assertions for the wake listen configuration bank
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound from the testbench top file
`timescale 1ns/1ns
module wlr_config_bank_props
  import wlr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic autonomous_wake_enable,
  input wire logic wake_up_timer_expired,
  input wire logic preamble_detected,
  input wire logic radio_power_up,
  input wire logic sleep_request,
  input wire logic listening,
  input wire logic [23:0] channel_word,
  input wire logic [FREQ_W-1:0] channel_word_hz,
  input wire logic [11:0] data_rate_word,
  input wire logic [BPS_W-1:0] data_rate_bps
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_wake;
    wake_up_timer_expired && autonomous_wake_enable && !radio_power_up |=> radio_power_up && listening;
  endproperty
  a_wake: assert property (p_wake) else $error("no power-up on wake");
  property p_no_wake;
    wake_up_timer_expired && !autonomous_wake_enable && !radio_power_up |=> !radio_power_up;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke with mode off");
  property p_sleep_fall;
    $fell(radio_power_up) && !$past(rst) |-> sleep_request;
  endproperty
  a_sleep_fall: assert property (p_sleep_fall) else $error("sleep without pulse");
  property p_sleep_one;
    sleep_request |=> !sleep_request;
  endproperty
  a_sleep_one: assert property (p_sleep_one) else $error("sleep pulse too long");
  property p_preamble;
    listening && preamble_detected |=> !listening && radio_power_up && !sleep_request;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble not honoured");
  property p_chan_mid;
    reg_wr && reg_addr == ADDR_CHANNEL_BYTE1 |=> channel_word[15:8] == $past(reg_wdata);
  endproperty
  a_chan_mid: assert property (p_chan_mid) else $error("channel middle byte");
  property p_rate_high;
    reg_wr && reg_addr == ADDR_BIT_RATE_HIGH |=> data_rate_word[11:8] == $past(reg_wdata[3:0]);
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("rate upper bits");
  property p_freq;
    !$past(rst) |-> channel_word_hz == FREQ_W'((49'(PFD_FREQ_HZ) * $past(channel_word)) >> FRAC_BITS);
  endproperty
  a_freq: assert property (p_freq) else $error("channel frequency");
  property p_bps;
    !$past(rst) |-> data_rate_bps == BPS_W'($past(data_rate_word) * RATE_STEP_BPS);
  endproperty
  a_bps: assert property (p_bps) else $error("data rate");
endmodule

/* File: tb_wake_listen_radio_config.sv */
// Purpose: Self-checking bench for the wake listen configuration bank
// Assumes: osc_tick high, or one pulse every third clock when slowed
// Notes: Registers reached through the byte-wide register port
`timescale 1ns/1ns
module tb_wake_listen_radio_config
  import wlr_pkg::*;
;
  logic clk_sys, rst, reg_wr, autonomous_wake_enable, rssi_detect_enable, osc_tick;
  logic wake_signal_detect_irq_enable, wake_up_timer_expired, preamble_detected;
  logic receive_done, rssi_valid, radio_power_up, rx_enable, sleep_request, listening;
  logic wake_signal_detect_irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic signed [DATA_W-1:0] rssi_dbm;
  logic [23:0] channel_word;
  logic [FREQ_W-1:0] channel_word_hz;
  logic [11:0] data_rate_word;
  logic [BPS_W-1:0] data_rate_bps;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  logic osc_slow;
  logic [1:0] osc_cnt;
  wlr_config_bank DUT (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .autonomous_wake_enable, .rssi_detect_enable, .wake_signal_detect_irq_enable,
    .wake_up_timer_expired, .osc_tick, .preamble_detected, .receive_done, .rssi_valid,
    .rssi_dbm, .radio_power_up, .rx_enable, .sleep_request, .listening,
    .wake_signal_detect_irq, .channel_word, .channel_word_hz, .data_rate_word, .data_rate_bps);
  task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    @(posedge clk_sys);
    chk("reg_rdata", 33'(e), 33'(reg_rdata));
  endtask
  task automatic expire();
    @(posedge clk_sys);
    wake_up_timer_expired <= 1'b1;
    @(posedge clk_sys);
    wake_up_timer_expired <= 1'b0;
  endtask
  task automatic wake(logic [7:0] dv, logic [7:0] wn, int e);
    wr(ADDR_TICK_DIVIDER, dv);
    wr(ADDR_LISTEN_WINDOW, wn);
    expire();
    n = 0;
    do begin
      @(posedge clk_sys);
      if (listening === 1'b1) n++;
    end while (listening === 1'b1 && n < 1000);
    chk("listen_cycles", 33'(e), 33'(n));
    chk("sleep_request", 33'(1), 33'(sleep_request));
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Oscillator pulses, phase restarted by each expiry
  always_ff @(posedge clk_sys) begin
    osc_cnt <= (rst || wake_up_timer_expired || osc_cnt == 2'd2) ? 2'd0 : osc_cnt + 2'd1;
    osc_tick <= !osc_slow || (osc_cnt == 2'd1 && !wake_up_timer_expired);
  end
  initial begin
    #1000000;
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    print_verdict();
  end
  initial begin
    rst <= 1'b1;
    osc_slow <= 1'b0;
    {reg_wr, autonomous_wake_enable, rssi_detect_enable, wake_signal_detect_irq_enable} <= '0;
    {wake_up_timer_expired, preamble_detected, receive_done, rssi_valid} <= '0;
    {reg_addr, reg_wdata, rssi_dbm} <= '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 'h105; a <= 'h10e; a++) rd(ADDR_W'(a), 8'h00);
    $display("Test reset values done");
    wr(ADDR_CHANNEL_BYTE0, 8'h34);
    wr(ADDR_CHANNEL_BYTE1, 8'h12);
    wr(ADDR_CHANNEL_BYTE2, 8'h9a);
    wr(ADDR_BIT_RATE_LOW, 8'hc8);
    wr(ADDR_BIT_RATE_HIGH, 8'ha3);
    wr(ADDR_WAKE_THRESHOLD, 8'h14);
    wr(11'h10e, 8'hff);
    rd(11'h10e, 8'h00);
    rd(ADDR_BIT_RATE_HIGH, 8'ha3);
    chk("channel_word", 33'h9a_1234, 33'(channel_word));
    chk("channel_word_hz", 33'((49'(PFD_FREQ_HZ) * 49'h9a_1234) >> 16), channel_word_hz);
    chk("data_rate_word", 33'h3c8, 33'(data_rate_word));
    chk("data_rate_bps", 33'(12'h3c8 * 100), 33'(data_rate_bps));
    $display("Test register map done");
    expire();
    @(posedge clk_sys);
    chk("radio_power_up", 33'(0), 33'(radio_power_up));
    autonomous_wake_enable <= 1'b1;
    wake(8'h00, 8'h00, 1);
    wake(8'h00, 8'h03, 3);
    wake(8'h01, 8'h02, 256);
    wake(8'h02, 8'h01, 256);
    osc_slow <= 1'b1;
    wake(8'h01, 8'h02, 768);
    osc_slow <= 1'b0;
    $display("Test listen window done");
    expire();
    repeat (10) @(posedge clk_sys);
    preamble_detected <= 1'b1;
    @(posedge clk_sys);
    preamble_detected <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk("radio_power_up", 33'(1), 33'(radio_power_up));
    chk("rx_enable", 33'(1), 33'(rx_enable));
    chk("listening", 33'(0), 33'(listening));
    {rssi_detect_enable, wake_signal_detect_irq_enable, rssi_valid} <= 3'b111;
    rssi_dbm <= -8'sd87;
    repeat (2) @(posedge clk_sys);
    chk("wake_signal_detect_irq", 33'(0), 33'(wake_signal_detect_irq));
    rssi_dbm <= -8'sd86;
    repeat (2) @(posedge clk_sys);
    chk("wake_signal_detect_irq", 33'(1), 33'(wake_signal_detect_irq));
    rssi_detect_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("wake_signal_detect_irq", 33'(0), 33'(wake_signal_detect_irq));
    rssi_detect_enable <= 1'b1;
    wake_signal_detect_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("wake_signal_detect_irq", 33'(0), 33'(wake_signal_detect_irq));
    receive_done <= 1'b1;
    @(posedge clk_sys);
    receive_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("radio_power_up", 33'(0), 33'(radio_power_up));
    wake_signal_detect_irq_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("wake_signal_detect_irq", 33'(0), 33'(wake_signal_detect_irq));
    $display("Test preamble and signal detect done");
    print_verdict();
  end
endmodule
bind wlr_config_bank wlr_config_bank_props u_props (.clk_sys, .rst, .reg_addr, .reg_wr,
  .reg_wdata, .autonomous_wake_enable, .wake_up_timer_expired, .preamble_detected,
  .radio_power_up, .sleep_request, .listening, .channel_word, .channel_word_hz,
  .data_rate_word, .data_rate_bps);
